// *** hw/sfb_boot_master.sv ***
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
// ****************************************
// Byte FIFO between link and decompressor
// ****************************************
module sfb_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sfb_fifo

// Summary of operation
// - 1000/1001 pick fast scheme, upgrade variant
// - 1101/1110 pick normal scheme, upgrade variant
// - Reset delay 100 ms low, 12 ms high
// - Reset holds status, done low; I/O off; status held low only in power-on reset or for an unknown scheme code
// - Pull-ups on after power-on reset until user mode, unless disable pin high
// - Reset, configure, initialize; reset on low
// - Release status after power-on reset
// - Device generates serial clock, is master
// - Scheme pins choose fast or normal source
// - Fast clock between 20 and 40 MHz
// - Read, decompress, load configuration memory
// - Four wires: clock, select, command, data
// - Commands leave on command output
// - Decompression stays available in this mode
// - Drive and capture on falling clock edge
// - Select driven low while configuring
// - Release done; initialize once seen high
module sfb_boot_master #(
  parameter int unsigned POR_LONG  = 32'(sfb_pkg::POR_LONG_CYC),
  parameter int unsigned POR_SHORT = 32'(sfb_pkg::POR_SHORT_CYC),
  parameter int          FIFO_W    = 8,
  parameter int          FIFO_D    = 16
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic [3:0]  boot_scheme_select,
  input  wire logic        reset_delay_select,
  input  wire logic        weak_pullup_disable,
  input  wire logic        reconfig_n,
  input  wire logic        status_in,
  output logic             status_out,
  output logic             status_oe,
  input  wire logic        done_in,
  output logic             done_out,
  output logic             done_oe,
  output logic             boot_serial_clock,
  output logic             flash_select_out_n,
  output logic             command_serial_out,
  input  wire logic        flash_data_in,
  output logic             user_io_en,
  output logic             weak_pullup_en,
  output logic             remote_upgrade,
  output logic             cfg_valid,
  output logic [7:0]       cfg_data,
  input  wire logic        cfg_ready
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NS = 10;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [3:0]    scheme_s;
  logic          reconfig_s, status_s, done_s, reset_delay_select_s;
  logic          pudis_s, data_s;

  assign pin_raw = {boot_scheme_select, reset_delay_select,
                    weak_pullup_disable, reconfig_n, status_in,
                    done_in, flash_data_in};
  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_raw[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end
  assign {scheme_s, reset_delay_select_s, pudis_s, reconfig_s, status_s,
          done_s, data_s} = s2_q;

  // ****************************************
  // Registers and state
  // ****************************************
  sfb_pkg::sfb_state_t st_q;
  logic        comp_q, soft_q, fast_q, ru_q, ack_q;
  logic [23:0] len_q, rx_bytes_q;
  logic [31:0] por_cnt_q;
  logic [8:0]  init_cnt_q;
  logic [1:0]  div_q;
  logic        boot_serial_clock_q, fall_p_q, cap_q, pend_q;
  logic [27:0] fall_cnt_q;
  logic [26:0] rx_bits_q;
  logic [31:0] cmd_sr_q;
  logic [6:0]  rx_sr_q;
  logic [7:0]  pend_data_q;
  logic [6:0]  run_q;
  logic        cfg_valid_q;
  logic [7:0]  cfg_data_q;
  logic        scheme_ok, scheme_fast, active, last_fall, stall;
  logic        toggle, wb_req, fifo_clr;
  logic        f_in_ready, f_out_valid, f_out_ready;
  logic [7:0]  f_out_data;
  logic [1:0]  half;
  logic [27:0] total_falls;

  // Unknown scheme codes keep the block in reset with status low
  assign scheme_fast = (scheme_s == sfb_pkg::SCH_FAST) ||
                       (scheme_s == sfb_pkg::SCH_FAST_RU);
  assign scheme_ok   = scheme_fast ||
                       (scheme_s == sfb_pkg::SCH_NORM) ||
                       (scheme_s == sfb_pkg::SCH_NORM_RU);
  assign active      = (st_q == sfb_pkg::ST_CMD) ||
                       (st_q == sfb_pkg::ST_DATA);
  assign total_falls = 28'(sfb_pkg::CMD_BITS) + {1'b0, len_q, 3'h0};
  assign last_fall   = (st_q == sfb_pkg::ST_DATA) &&
                       (fall_cnt_q == total_falls);
  // Clock parks low while a byte waits for FIFO room
  assign stall  = !boot_serial_clock_q && (pend_q || last_fall);
  assign half   = fast_q ? 2'(sfb_pkg::FAST_HALF_CYC)
                         : 2'(sfb_pkg::NORM_HALF_CYC);
  assign toggle = active && (div_q == half - 2'h1) && !stall;
  assign wb_req = wb_cyc_i && wb_stb_i;

  // ****************************************
  // Wishbone slave
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_q    <= wb_req && !ack_q;
      wb_dat_o <= 32'h0;
      if (wb_req && !ack_q && !wb_we_i) begin
        if (wb_adr_i == sfb_pkg::REG_CTRL) begin
          wb_dat_o <= {30'h0, 1'b0, comp_q};
        end else if (wb_adr_i == sfb_pkg::REG_LEN) begin
          wb_dat_o <= {8'h00, len_q};
        end else if (wb_adr_i == sfb_pkg::REG_STAT) begin
          wb_dat_o <= {26'h0, scheme_ok, ru_q, fast_q, st_q};
        end else if (wb_adr_i == sfb_pkg::REG_COUNT) begin
          wb_dat_o <= {8'h00, rx_bytes_q};
        end
      end
    end
  end
  assign wb_ack_o = ack_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      comp_q <= 1'b0;
      soft_q <= 1'b0;
      len_q  <= sfb_pkg::LEN_RST;
    end else begin
      soft_q <= 1'b0;
      if (wb_req && !ack_q && wb_we_i) begin
        if (wb_adr_i == sfb_pkg::REG_CTRL && wb_sel_i[0]) begin
          comp_q <= wb_dat_i[sfb_pkg::CTRL_COMP];
          soft_q <= wb_dat_i[sfb_pkg::CTRL_RECFG];
        end else if (wb_adr_i == sfb_pkg::REG_LEN) begin
          for (int b = 0; b < 3; b++) begin
            if (wb_sel_i[b]) begin
              len_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
          end
        end
      end
    end
  end

  // ****************************************
  // Configuration sequence
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q       <= sfb_pkg::ST_POR;
      por_cnt_q  <= 32'h0;
      init_cnt_q <= 9'h0;
      fast_q     <= 1'b0;
      ru_q       <= 1'b0;
    end else begin
      case (st_q)
        sfb_pkg::ST_POR: begin
          por_cnt_q <= por_cnt_q + 32'h1;
          if (por_cnt_q >= (reset_delay_select_s ? POR_SHORT : POR_LONG)) begin
            st_q <= sfb_pkg::ST_RESET;
          end
        end
        sfb_pkg::ST_RESET: begin
          if (reconfig_s && status_s && scheme_ok && !soft_q) begin
            st_q   <= sfb_pkg::ST_CMD;
            fast_q <= scheme_fast;
            ru_q   <= (scheme_s == sfb_pkg::SCH_FAST_RU) ||
                      (scheme_s == sfb_pkg::SCH_NORM_RU);
          end
        end
        default: begin
          if (!reconfig_s || !status_s || soft_q) begin
            st_q <= sfb_pkg::ST_RESET;
          end else begin
            case (st_q)
              sfb_pkg::ST_CMD: begin
                if (toggle && boot_serial_clock_q &&
                    fall_cnt_q == 28'(sfb_pkg::CMD_BITS - 1)) begin
                  st_q <= sfb_pkg::ST_DATA;
                end
              end
              sfb_pkg::ST_DATA: begin
                if (last_fall && !pend_q && !cap_q && !fall_p_q) begin
                  st_q <= sfb_pkg::ST_FLUSH;
                end
              end
              sfb_pkg::ST_FLUSH: begin
                if (!f_out_valid && run_q == 7'h0 && !cfg_valid_q) begin
                  st_q <= sfb_pkg::ST_WAITD;
                end
              end
              sfb_pkg::ST_WAITD: begin
                init_cnt_q <= 9'h0;
                if (done_s) begin
                  st_q <= sfb_pkg::ST_INIT;
                end
              end
              sfb_pkg::ST_INIT: begin
                init_cnt_q <= init_cnt_q + 9'h1;
                if (init_cnt_q == 9'(sfb_pkg::INIT_CYC - 1)) begin
                  st_q <= sfb_pkg::ST_USER;
                end
              end
              default: begin
                st_q <= st_q;
              end
            endcase
          end
        end
      endcase
    end
  end

  // ****************************************
  // Serial link
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_q      <= 2'h0;
      boot_serial_clock_q     <= 1'b0;
      fall_p_q   <= 1'b0;
      fall_cnt_q <= 28'h0;
      cmd_sr_q   <= 32'h0;
    end else if (!active) begin
      div_q      <= 2'h0;
      boot_serial_clock_q     <= 1'b0;
      fall_p_q   <= 1'b0;
      fall_cnt_q <= 28'h0;
      cmd_sr_q   <= {sfb_pkg::READ_CMD, sfb_pkg::START_ADDR};
    end else begin
      div_q    <= (toggle || div_q == half - 2'h1) ? 2'h0
                                                  : div_q + 2'h1;
      fall_p_q <= 1'b0;
      if (toggle) begin
        boot_serial_clock_q <= !boot_serial_clock_q;
        if (boot_serial_clock_q) begin
          fall_cnt_q <= fall_cnt_q + 28'h1;
          cmd_sr_q   <= {cmd_sr_q[30:0], 1'b0};
          fall_p_q   <= (fall_cnt_q >= 28'(sfb_pkg::CMD_BITS));
        end
      end
    end
  end
  assign boot_serial_clock  = boot_serial_clock_q;
  assign flash_select_out_n = !active;
  assign command_serial_out = cmd_sr_q[31];

  // Capture two cycles after the fall: synchroniser latency
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cap_q       <= 1'b0;
      rx_sr_q     <= 7'h0;
      rx_bits_q   <= 27'h0;
      rx_bytes_q  <= 24'h0;
      pend_q      <= 1'b0;
      pend_data_q <= 8'h00;
    end else if (st_q == sfb_pkg::ST_RESET) begin
      cap_q      <= 1'b0;
      rx_bits_q  <= 27'h0;
      rx_bytes_q <= 24'h0;
      pend_q     <= 1'b0;
    end else begin
      cap_q <= fall_p_q;
      if (pend_q && f_in_ready) begin
        pend_q <= 1'b0;
      end
      if (cap_q) begin
        rx_sr_q   <= {rx_sr_q[5:0], data_s};
        rx_bits_q <= rx_bits_q + 27'h1;
        if (rx_bits_q[2:0] == 3'h7) begin
          pend_q      <= 1'b1;
          pend_data_q <= {rx_sr_q, data_s};
          rx_bytes_q  <= rx_bytes_q + 24'h1;
        end
      end
    end
  end

  assign fifo_clr = (st_q == sfb_pkg::ST_RESET);
  sfb_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk       (sys_clk),
    .rstn      (rstn),
    .clr       (fifo_clr),
    .in_valid  (pend_q),
    .in_ready  (f_in_ready),
    .in_data   (pend_data_q),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // ****************************************
  // Decompression and configuration memory
  // ****************************************
  // Compressed byte with top bit set expands to that many plus one zeros
  assign f_out_ready = (run_q == 7'h0) && (!cfg_valid_q || cfg_ready);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      run_q       <= 7'h0;
      cfg_valid_q <= 1'b0;
      cfg_data_q  <= 8'h00;
    end else if (fifo_clr) begin
      run_q       <= 7'h0;
      cfg_valid_q <= 1'b0;
    end else if (!cfg_valid_q || cfg_ready) begin
      cfg_valid_q <= 1'b0;
      if (run_q != 7'h0) begin
        run_q       <= run_q - 7'h1;
        cfg_valid_q <= 1'b1;
        cfg_data_q  <= 8'h00;
      end else if (f_out_valid) begin
        cfg_valid_q <= 1'b1;
        if (comp_q && f_out_data[7]) begin
          run_q      <= f_out_data[6:0];
          cfg_data_q <= 8'h00;
        end else begin
          cfg_data_q <= f_out_data;
        end
      end
    end
  end
  assign cfg_valid = cfg_valid_q;
  assign cfg_data  = cfg_data_q;

  // ****************************************
  // Open-drain lines and I/O control
  // ****************************************
  assign status_out     = 1'b0;
  assign status_oe      = (st_q == sfb_pkg::ST_POR) ||
                          (st_q == sfb_pkg::ST_RESET && !scheme_ok);
  assign done_out       = 1'b0;
  assign done_oe        = (st_q < sfb_pkg::ST_WAITD);
  assign user_io_en     = (st_q == sfb_pkg::ST_USER);
  assign weak_pullup_en = (st_q != sfb_pkg::ST_POR) &&
                          (st_q != sfb_pkg::ST_USER) && !pudis_s;
  assign remote_upgrade = ru_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_por_lines: assert property (st_q == sfb_pkg::ST_POR |->
    status_oe && done_oe && !user_io_en)
    else $error("lines not held during power-on reset");
  a_reset_entry: assert property (
    (st_q > sfb_pkg::ST_RESET && (!reconfig_s || !status_s))
    |=> st_q == sfb_pkg::ST_RESET)
    else $error("reset request not obeyed");
  a_status_rel: assert property (
    $past(st_q) == sfb_pkg::ST_POR && st_q == sfb_pkg::ST_RESET
    && scheme_ok |-> !status_oe)
    else $error("status not released after power-on reset");
  a_select_low: assert property (active |->
    !flash_select_out_n) else $error("select high in configuration");
  a_clk_park: assert property (!active |-> ##1
    (!boot_serial_clock || active))
    else $error("serial clock runs outside configuration");
  a_fast_half: assert property (
    $rose(boot_serial_clock_q) && fast_q && active |=> !boot_serial_clock_q)
    else $error("fast clock high phase wrong");
  a_norm_half: assert property (
    $rose(boot_serial_clock_q) && !fast_q && active |=> boot_serial_clock_q ##1 !boot_serial_clock_q)
    else $error("normal clock high phase wrong");
  a_cmd_first: assert property (
    $rose(st_q == sfb_pkg::ST_CMD) |->
    command_serial_out == sfb_pkg::READ_CMD[7] && !boot_serial_clock_q)
    else $error("read command not presented first");
  a_cmd_change: assert property (
    $changed(command_serial_out) && active |-> $fell(boot_serial_clock_q))
    else $error("command changed off a falling edge");
  a_init_gate: assert property (
    $rose(st_q == sfb_pkg::ST_INIT) |-> $past(done_s) && !done_oe)
    else $error("initialization before done seen high");
  a_pullup_ctl: assert property (
    st_q == sfb_pkg::ST_CMD |-> weak_pullup_en == !pudis_s)
    else $error("pull-up control wrong during configuration");

  c_user_mode: cover property ($rose(st_q == sfb_pkg::ST_USER));
  c_zero_run:  cover property (comp_q && run_q != 7'h0 && cfg_ready);
  c_stall:     cover property (stall && pend_q && active);
  c_reconfig:  cover property (st_q == sfb_pkg::ST_USER ##1
                               st_q == sfb_pkg::ST_RESET);
endmodule : sfb_boot_master

// *** hw/sfb_pkg.sv ***
package sfb_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned SYS_CLK_HZ   = 50_000_000;
  localparam int unsigned POR_LONG_MS  = 100;
  localparam int unsigned POR_SHORT_MS = 12;
  localparam longint unsigned POR_LONG_CYC =
    longint'(POR_LONG_MS) * longint'(SYS_CLK_HZ) / 64'd1000;
  localparam longint unsigned POR_SHORT_CYC =
    longint'(POR_SHORT_MS) * longint'(SYS_CLK_HZ) / 64'd1000;
  localparam int unsigned FAST_MAX_HZ  = 40_000_000;
  localparam int unsigned NORM_MAX_HZ  = 20_000_000;
  // Half period rounds up so the clock never exceeds its maximum
  localparam int unsigned FAST_HALF_CYC =
    (SYS_CLK_HZ + 2 * FAST_MAX_HZ - 1) / (2 * FAST_MAX_HZ);
  localparam int unsigned NORM_HALF_CYC =
    (SYS_CLK_HZ + 2 * NORM_MAX_HZ - 1) / (2 * NORM_MAX_HZ);
  localparam int unsigned INIT_CYC     = 299;
  // ****************************************
  // Boot schemes and flash command
  // ****************************************
  localparam logic [3:0]  SCH_FAST     = 4'h8;
  localparam logic [3:0]  SCH_FAST_RU  = 4'h9;
  localparam logic [3:0]  SCH_NORM     = 4'hD;
  localparam logic [3:0]  SCH_NORM_RU  = 4'hE;
  localparam logic [7:0]  READ_CMD     = 8'h03;
  localparam logic [23:0] START_ADDR   = 24'h000000;
  localparam int unsigned CMD_BITS     = 32;
  // ****************************************
  // Registers
  // ****************************************
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_LEN      = 4'h4;
  localparam logic [3:0]  REG_STAT     = 4'h8;
  localparam logic [3:0]  REG_COUNT    = 4'hC;
  localparam int unsigned CTRL_COMP    = 0;
  localparam int unsigned CTRL_RECFG   = 1;
  localparam logic [23:0] LEN_RST      = 24'h000100;
  localparam int unsigned STAT_FAST    = 3;
  localparam int unsigned STAT_RU      = 4;
  localparam int unsigned STAT_OK      = 5;

  typedef enum logic [2:0] {
    ST_POR   = 3'h0,
    ST_RESET = 3'h1,
    ST_CMD   = 3'h2,
    ST_DATA  = 3'h3,
    ST_FLUSH = 3'h4,
    ST_WAITD = 3'h5,
    ST_INIT  = 3'h6,
    ST_USER  = 3'h7
  } sfb_state_t;
endpackage : sfb_pkg

// *** tb/sfb_flash_model.sv ***
`timescale 1ns/1ns
// ****************************************
// Serial flash stand-in
// ****************************************
module sfb_flash_model (
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic [31:0]      cmd_q
);
  int         rises;
  int         falls;
  logic [7:0] byte_v;
  // Command and address latched on the rising clock
  always @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rises <= 0;
    end else if (rises < 32) begin
      cmd_q <= {cmd_q[30:0], mosi};
      rises <= rises + 1;
    end
  end
  // Data leaves MSB first on the falling clock; pull-up when idle
  always @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      falls <= 0;
      miso  <= 1'b1;
    end else begin
      falls  <= falls + 1;
      byte_v = 8'h5A ^ 8'((falls - 31) / 8);
      miso   <= (falls >= 31) ? byte_v[7 - (falls - 31) % 8] : 1'b1;
    end
  end
endmodule : sfb_flash_model

// *** tb/sfb_boot_master_tb.sv ***
`timescale 1ns/1ns
// ****************************************
// Boot master bench
// ****************************************
module sfb_boot_master_tb;
  localparam int PL  = 200;
  localparam int PS  = 50;
  localparam int LEN = 20;
  typedef struct packed {
    logic [3:0] sch;
    logic [2:0] stat;
    logic       wpd;
    logic       stall;
  } sfb_row_t;
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [3:0]  adr     = 4'h0;
  logic [31:0] dat_i   = 32'h0;
  logic        we      = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic [3:0]  sch     = 4'h8;
  logic        rds     = 1'b0;
  logic        wpd     = 1'b0;
  logic        rcfg_n  = 1'b1;
  logic        cr      = 1'b1;
  logic        cmp     = 1'b0;
  logic        so, dno;
  logic [31:0] dat_o, cmd, q;
  logic [7:0]  cd, exp_b;
  logic        ack, st_oe, dn_oe, sck, cs_n, mosi, miso, uio, wpu, ru, cv;
  int          fail_count  = 0;
  int          checks_done = 0;
  int          got, n;
  int          hi_run = 0;
  int          hi_len = 0;
  sfb_row_t    rows [4] = '{{4'h8, 3'h5, 1'h0, 1'h1}, {4'h9, 3'h7, 1'h1, 1'h0},
                            {4'hD, 3'h4, 1'h0, 1'h0}, {4'hE, 3'h6, 1'h1, 1'h1}};

  always #10 sys_clk = ~sys_clk;

  sfb_boot_master #(.POR_LONG(PL), .POR_SHORT(PS)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(dat_i),
    .wb_dat_o(dat_o), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .boot_scheme_select(sch),
    .reset_delay_select(rds), .weak_pullup_disable(wpd),
    .reconfig_n(rcfg_n), .status_in(~st_oe), .status_out(so),
    .status_oe(st_oe), .done_in(~dn_oe), .done_out(dno), .done_oe(dn_oe),
    .boot_serial_clock(sck), .flash_select_out_n(cs_n),
    .command_serial_out(mosi), .flash_data_in(miso), .user_io_en(uio),
    .weak_pullup_en(wpu), .remote_upgrade(ru), .cfg_valid(cv),
    .cfg_data(cd), .cfg_ready(cr));

  sfb_flash_model fl (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
                      .cmd_q(cmd));

  // ****************************************
  // Monitors: clock high phase, delivered bytes
  // ****************************************
  always @(posedge sys_clk) begin
    if (sck === 1'b1) begin
      hi_run++;
    end else begin
      if (hi_run > 0) hi_len = hi_run;
      hi_run = 0;
    end
    if (cv === 1'b1 && cr === 1'b1) begin
      // With compression on, stream byte 128 is a run code of zeros
      exp_b = (cmp && got >= 128) ? 8'h00 : 8'h5A ^ 8'(got);
      check({24'h0, cd}, {24'h0, exp_b});
      got++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // Every wait on a condition goes through here so a hang always ends the run
  task automatic step(inout int k, input int lim);
    @(posedge sys_clk);
    k++;
    if (k > lim) begin
      fail_count++;
      $display("mismatch at %0t: wait ran out", $time);
      stop_test();
    end
  endtask : step

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    adr <= a;
    dat_i <= d;
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      step(k, 20);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    step(k, 40);
  endtask : wb

  task automatic boot(input sfb_row_t r);
    int k;
    k = 0;
    sch <= r.sch;
    wpd <= r.wpd;
    cr <= ~r.stall;
    rcfg_n <= 1'b0;
    repeat (5) step(k, 9);
    check({st_oe, dn_oe, uio, cs_n}, 4'h5);
    check({so, dno}, 2'h0);
    got = 0;
    rcfg_n <= 1'b1;
    k = 0;
    while (cs_n !== 1'b0) step(k, 40);
    wb(1'b0, 4'h8, 32'h0);
    check(q[5:3], r.stat);
    check({ru, wpu}, {r.stat[1], ~r.wpd});
    if (r.stall) begin
      // Stalled memory fills the buffer, then the link must park
      repeat (800) @(posedge sys_clk);
      check({sck, 31'(got)}, 32'h0);
      cr <= 1'b1;
    end
    k = 0;
    while (dn_oe !== 1'b0) step(k, 9000);
    k = 0;
    while (uio !== 1'b1) step(k, 400);
    check(k >= 299 && k <= 305, 1'b1);
    check(got, LEN);
    check(cmd, 32'h03000000);
    check(hi_len, r.stat[0] ? 1 : 2);
    check(wpu, 1'b0);
  endtask : boot

  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    n = 0;
    while (st_oe !== 1'b0) step(n, PL + 40);
    check(n >= PL && n <= PL + 10, 1'b1);
    wb(1'b1, 4'h4, LEN);
    wb(1'b0, 4'h4, 32'h0);
    check(q, LEN);
    wb(1'b0, 4'h2, 32'h0);
    check(q, 32'h0);
    $display("test por_and_regs done");
    foreach (rows[i]) begin
      boot(rows[i]);
      $display("test row %0d done", i);
    end
    // Soft restart, compressed: 129 bytes, last one expands to 91 zeros
    wb(1'b1, 4'h4, 32'h81);
    got = 0;
    cmp = 1'b1;
    wb(1'b1, 4'h0, 32'h3);
    n = 0;
    while (dn_oe !== 1'b0) step(n, 9000);
    while (uio !== 1'b1) step(n, 9400);
    check(got, 32'hDB);
    cmp = 1'b0;
    $display("test compressed done");
    // Abort while the read command is still shifting out
    n = 0;
    rcfg_n <= 1'b0;
    repeat (3) step(n, 9);
    rcfg_n <= 1'b1;
    while (cs_n !== 1'b0) step(n, 60);
    repeat (100) @(posedge sys_clk);
    rcfg_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check({st_oe, cs_n}, 2'h1);
    $display("test abort done");
    // Unlisted scheme code must never start a boot
    sch <= 4'h0;
    rcfg_n <= 1'b1;
    repeat (50) @(posedge sys_clk);
    check({st_oe, cs_n}, 2'h3);
    wb(1'b0, 4'h8, 32'h0);
    check(q[5], 1'b0);
    $display("test bad_scheme done");
    // Short power-on delay
    rstn <= 1'b0;
    rds <= 1'b1;
    sch <= 4'h8;
    repeat (3) @(posedge sys_clk);
    check({st_oe, dn_oe, uio, wpu}, 4'hC);
    rstn <= 1'b1;
    n = 0;
    while (st_oe !== 1'b0) step(n, PS + 40);
    check(n >= PS && n <= PS + 10, 1'b1);
    $display("test short_por done");
    stop_test();
  end
endmodule : sfb_boot_master_tb
